// *** inc/tof_seq_pkg.sv ***
/*
  constants for the time-of-flight measurement sequencer.
  assumes a single 100 MHz system clock; the reference clock and all
  host pins arrive asynchronously and are synchronised inside the block.
*/
`default_nettype none
package tof_seq_pkg;
  localparam int unsigned DIV_W = 3;
  localparam int unsigned NUM_W = 5;
  localparam int unsigned MODE_W = 2;
  localparam int unsigned START_CAP = 3;
  localparam logic [MODE_W-1:0] MODE_MAX = 2'h2;
  localparam int unsigned T_EN_TRIG_NS = 50;
  localparam real T_RES_TRIG_US = 3.05;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned EN_TRIG_CYC = (T_EN_TRIG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RES_TRIG_CYC = int'(T_RES_TRIG_US * 1000.0) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TX = 2'b01,
    ST_RX = 2'b10
  } seq_state_t;
endpackage : tof_seq_pkg
`default_nettype wire

// *** logic/tof_sync2.sv ***
/*
  two-flop synchroniser for a bus of asynchronous levels.
  assumes nothing reads the first stage.
*/
`default_nettype none
module tof_sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : tof_sync2
`default_nettype wire

// *** logic/tof_sequencer.sv ***
/*
  measurement sequencer: trigger in, start reference, transmit burst on the
  divided reference clock, then stop pulses from the comparators.
  assumes the reference clock, trigger, enable and comparators are async pins;
  configuration arrives as static levels already decoded from the serial port.
*/
`default_nettype none
module tof_sequencer
  import tof_seq_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // host pins
  input wire logic enable,
  input wire logic trigger,
  input wire logic reference_clock_input,
  // configuration
  input wire logic [tof_seq_pkg::DIV_W-1:0] tx_clock_divide_exponent,
  input wire logic [tof_seq_pkg::NUM_W-1:0] tx_pulse_count,
  input wire logic [tof_seq_pkg::MODE_W-1:0] op_mode,
  // comparators
  input wire logic echo_qual_cmp,
  input wire logic zero_cross_cmp,
  // outputs
  output logic start,
  output logic stop,
  output logic tx_out,
  output logic busy
);
  import tof_seq_pkg::*;

  logic en_s, trig_s, ref_s, qual_s, zc_s;
  tof_sync2 #(.W(5)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({enable, trigger, reference_clock_input, echo_qual_cmp, zero_cross_cmp}),
    .q({en_s, trig_s, ref_s, qual_s, zc_s})
  );

  seq_state_t state_r, state_nxt;
  logic trig_d_r, ref_d_r, zc_d_r;
  logic [7:0] div_r, div_nxt;
  logic [NUM_W-1:0] pcnt_r, pcnt_nxt;
  logic [1:0] speriod_r, speriod_nxt;
  logic half_r, half_nxt;
  logic start_nxt, stop_nxt, tx_nxt, busy_nxt;
  logic qualified_r, qualified_nxt;
  logic trig_rise, ref_rise, zc_rise, tick, cfg_ok;
  logic [7:0] div_last;

  assign trig_rise = trig_s & ~trig_d_r;
  assign ref_rise = ref_s & ~ref_d_r;
  assign zc_rise = zc_s & ~zc_d_r;
  // half-period of the transmit clock is 2^exp reference cycles
  assign div_last = 8'((9'h001 << tx_clock_divide_exponent) - 9'h001);
  assign tick = ref_rise && (div_r == div_last);
  assign cfg_ok = (op_mode <= MODE_MAX) && (tx_pulse_count != '0);

  always_comb
  begin
    state_nxt = state_r;
    div_nxt = div_r;
    pcnt_nxt = pcnt_r;
    speriod_nxt = speriod_r;
    half_nxt = half_r;
    start_nxt = start;
    stop_nxt = 1'b0;
    tx_nxt = tx_out;
    qualified_nxt = qualified_r;
    unique case (state_r)
      ST_IDLE:
      begin
        if (trig_rise && en_s && cfg_ok)
        begin
          state_nxt = ST_TX;
          div_nxt = 8'h00;
          pcnt_nxt = tx_pulse_count;
          speriod_nxt = 2'h0;
          half_nxt = 1'b0;
          start_nxt = 1'b1;
          tx_nxt = 1'b1;
          qualified_nxt = 1'b0;
        end
      end
      ST_TX:
      begin
        if (ref_rise)
        begin
          div_nxt = tick ? 8'h00 : 8'(div_r + 8'h01);
        end
        if (tick)
        begin
          half_nxt = ~half_r;
          if (!half_r)
          begin
            tx_nxt = 1'b0;
          end
          else
          begin
            // one full transmit period ends here
            speriod_nxt = 2'(speriod_r + 2'h1);
            pcnt_nxt = NUM_W'(pcnt_r - 1'b1);
            if (speriod_r == 2'(START_CAP - 1) || pcnt_r == NUM_W'(1))
            begin
              start_nxt = 1'b0;
            end
            if (pcnt_r == NUM_W'(1))
            begin
              state_nxt = ST_RX;
              start_nxt = 1'b0;
            end
            else
            begin
              tx_nxt = 1'b1;
            end
          end
        end
      end
      ST_RX:
      begin
        // every mode ends when the host drops enable or raises trigger again
        if (qual_s)
        begin
          qualified_nxt = 1'b1;
        end
        if (qualified_r && zc_rise)
        begin
          stop_nxt = 1'b1;
        end
        if (!en_s || trig_rise)
        begin
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
    busy_nxt = (state_nxt != ST_IDLE);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      trig_d_r <= 1'b0;
      ref_d_r <= 1'b0;
      zc_d_r <= 1'b0;
      div_r <= 8'h00;
      pcnt_r <= '0;
      speriod_r <= 2'h0;
      half_r <= 1'b0;
      qualified_r <= 1'b0;
      start <= 1'b0;
      stop <= 1'b0;
      tx_out <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      trig_d_r <= trig_s;
      ref_d_r <= ref_s;
      zc_d_r <= zc_s;
      div_r <= div_nxt;
      pcnt_r <= pcnt_nxt;
      speriod_r <= speriod_nxt;
      half_r <= half_nxt;
      qualified_r <= qualified_nxt;
      start <= start_nxt;
      stop <= stop_nxt;
      tx_out <= tx_nxt;
      busy <= busy_nxt;
    end
  end

  a_start_needs_trigger: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(start) |-> $past(trig_rise) && $past(state_r) == ST_IDLE)
    else $error("start rose without a trigger");
  a_start_with_tx: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(start) |-> $rose(tx_out))
    else $error("transmit did not begin with start");
  a_start_gives_busy: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(start) |-> busy)
    else $error("start without busy");
  a_trig_ignored_busy: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == ST_TX |=> !$rose(start))
    else $error("restart during burst");
  a_stop_qualified: assert property (@(posedge clk_sys) disable iff (rst)
    stop |-> $past(qualified_r) && $past(state_r) == ST_RX)
    else $error("stop without qualification");
  a_stop_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    stop |=> !stop)
    else $error("stop longer than one cycle");
  a_start_ends_burst: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(start) |-> !tx_out || state_r == ST_TX)
    else $error("start fell out of step with transmit");
  a_burst_count: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == ST_TX && state_nxt == ST_RX) |-> pcnt_r == NUM_W'(1))
    else $error("burst ended early");
  a_mode_legal: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(start) |-> $past(op_mode) <= MODE_MAX)
    else $error("cycle with illegal mode");
endmodule : tof_sequencer
`default_nettype wire

// *** testbench/tof_host_model.sv ***
/*
  host side model: free-running reference clock and receive comparators.
  assumes echo() is called from the bench at a falling clock edge.
*/
`default_nettype none
module tof_host_model (
  // device pins
  output logic reference_clock_input,
  output logic echo_qual_cmp,
  output logic zero_cross_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    reference_clock_input = 1'b0;
    echo_qual_cmp = 1'b0;
    zero_cross_cmp = 1'b0;
  end
  // reference clock, 120 ns period
  always #60 reference_clock_input = ~reference_clock_input;
  // k zero crossings, optionally inside a qualified echo
  task automatic echo(input bit qual, input int k);
    echo_qual_cmp = qual;
    repeat (k)
    begin
      #100 zero_cross_cmp = 1'b1;
      #100 zero_cross_cmp = 1'b0;
    end
    #100 echo_qual_cmp = 1'b0;
  endtask : echo
endmodule : tof_host_model
`default_nettype wire

// *** testbench/tb_tof_measurement_sequencer.sv ***
/*
  random and corner bursts through the sequencer, counting pulses.
  assumes the host model's 120 ns reference clock.
*/
`default_nettype none
module tb_tof_measurement_sequencer;
  import tof_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, enable, trigger, reference_clock_input;
  logic echo_qual_cmp, zero_cross_cmp, start, stop, tx_out, busy;
  logic tx_q, start_q, aligned, clr;
  logic [DIV_W-1:0] tx_clock_divide_exponent;
  logic [NUM_W-1:0] tx_pulse_count;
  logic [MODE_W-1:0] op_mode;
  int error_cnt, samples_checked, tx_cnt, stop_cnt, start_w;
  tof_host_model i_tof_host_model (.reference_clock_input, .echo_qual_cmp, .zero_cross_cmp);
  tof_sequencer i_tof_sequencer (.clk_sys, .rst, .enable, .trigger, .reference_clock_input,
    .tx_clock_divide_exponent, .tx_pulse_count, .op_mode, .echo_qual_cmp,
    .zero_cross_cmp, .start, .stop, .tx_out, .busy);
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    tx_q <= tx_out;
    start_q <= start;
    // per-run counters are cleared here only, so each has one writer
    if (clr)
    begin
      aligned <= 1'b0;
      tx_cnt <= 0;
      stop_cnt <= 0;
      start_w <= 0;
    end
    else
    begin
      if (start && !start_q)
        aligned <= tx_out && !tx_q;
      if (tx_out && !tx_q)
        tx_cnt <= tx_cnt + 1;
      if (stop)
        stop_cnt <= stop_cnt + 1;
      if (start)
        start_w <= start_w + 1;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %0d expected %0d", $time, msg, seen, exp);
    end
  endtask : check
  task automatic run(input int d, input int n, input int m, input bit poke);
    int e;
    int lim;
    @(negedge clk_sys);
    tx_clock_divide_exponent = d[DIV_W-1:0];
    tx_pulse_count = n[NUM_W-1:0];
    op_mode = m[MODE_W-1:0];
    clr = 1'b1;
    enable = 1'b1;
    @(negedge clk_sys);
    clr = 1'b0;
    repeat (EN_TRIG_CYC) @(negedge clk_sys);
    trigger = 1'b1;
    lim = 0;
    while (busy !== 1'b1 && lim < 20)
    begin
      @(negedge clk_sys);
      lim++;
    end
    check({31'h0, busy}, (n != 0 && m <= 2), "trigger taken");
    trigger = 1'b0;
    if (busy === 1'b1)
    begin
      // a second trigger rise in mid-burst must be ignored; early enough
      // to land inside even the shortest burst
      repeat (2) @(negedge clk_sys);
      trigger = poke;
      repeat (n * (12 << (d + 1)) + 40) @(negedge clk_sys);
      trigger = 1'b0;
      e = (n < 3 ? n : 3) * (12 << (d + 1));
      check(tx_cnt, n, "tx pulses");
      check({31'h0, aligned}, 1, "tx with start");
      check(start_w + 14 >= e && start_w <= e + 14, 1, "start width");
      i_tof_host_model.echo(1'b0, 2);
      check(stop_cnt, 0, "unqualified stop");
      i_tof_host_model.echo(1'b1, 1 + n % 3);
      repeat (10) @(negedge clk_sys);
      check(stop_cnt, 1 + n % 3, "stop pulses");
    end
    enable = 1'b0;
    repeat (20) @(negedge clk_sys);
    check({31'h0, busy}, 0, "back to idle");
  endtask : run
  task automatic tally_and_finish();
    if (error_cnt == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    // over three times the longest possible test of about 110 us
    #400000;
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    clk_sys = 1'b0;
    rst = 1'b1;
    enable = 1'b0;
    trigger = 1'b0;
    clr = 1'b0;
    tx_clock_divide_exponent = '0;
    tx_pulse_count = 5'h1;
    op_mode = 2'h0;
    error_cnt = 0;
    samples_checked = 0;
    void'($urandom(32'h74c7));
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    repeat (RES_TRIG_CYC) @(negedge clk_sys);
    check({31'h0, busy}, 0, "no cycle unasked");
    for (int i = 1; i <= 4; i++)
      run(2, i, i % 3, 1'b1);
    run(0, 0, 0, 1'b0);
    run(0, 1, 3, 1'b0);
    repeat (12)
      run($urandom_range(0, 2), $urandom_range(1, 6), $urandom_range(0, 2), $urandom_range(0, 1));
    tally_and_finish();
  end
endmodule : tb_tof_measurement_sequencer
`default_nettype wire
